// ==== common/asq_map.svh ====
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH

// register byte offsets
`define ASQ_OFF_CTRL      8'h00
`define ASQ_OFF_MODE      8'h04
`define ASQ_OFF_STAT      8'h08
`define ASQ_OFF_DELAY     8'h0C
`define ASQ_OFF_MON0      8'h10
`define ASQ_OFF_MON1      8'h14

// control register bits
`define ASQ_CTRL_NSTART   0
`define ASQ_CTRL_PSTART   1
`define ASQ_CTRL_POWER    2
`define ASQ_CTRL_DUAL     3
`define ASQ_CTRL_DSEL     4

// mode register fields
`define ASQ_MODE_RS       1:0
`define ASQ_MODE_SCAN     0
`define ASQ_MODE_REP      1
`define ASQ_MODE_NCH      5:2
`define ASQ_MODE_PCH      9:6
`define ASQ_MODE_SFIRST   13:10
`define ASQ_MODE_SSPAN    17:14
`define ASQ_MODE_ITM      20:18

// status register bits
`define ASQ_STAT_NDONE    0
`define ASQ_STAT_NBUSY    1
`define ASQ_STAT_PDONE    2
`define ASQ_STAT_PBUSY    3

// start delay register
`define ASQ_DELAY_RST     8'h27
`define ASQ_DELAY_MIN     8'h01
`define ASQ_DELAY_F       7:0

// monitor register fields
`define ASQ_MON_EN        0
`define ASQ_MON_CHAN      4:1
`define ASQ_MON_DIR       5
`define ASQ_MON_METH      6
`define ASQ_MON_LIM       10:7
`define ASQ_MON_THR       27:16

`endif

// ==== common/asq_pkg.sv ====
package asq_pkg;

	typedef enum logic [2:0] {
		ASQ_IDLE = 3'b001,
		ASQ_NORM = 3'b010,
		ASQ_PRIO = 3'b100
	} asq_fsm_t;

	typedef struct packed {
		logic        en;
		logic [3:0]  chan;
		logic        dir;
		logic        method;
		logic [3:0]  limit;
		logic [11:0] thr;
	} asq_mon_t;

	typedef struct packed {
		logic        power;
		logic        dual;
		logic        dsel;
		logic [1:0]  rs;
		logic [3:0]  nch;
		logic [3:0]  pch;
		logic [3:0]  sfirst;
		logic [3:0]  sspan;
		logic [2:0]  repeat_irq_interval;
		logic [7:0]  delay;
	} asq_cfg_t;

	typedef struct packed {
		asq_cfg_t          cfg;
		asq_mon_t [1:0]    mon;
		logic [1:0][3:0]   mcnt;
		asq_fsm_t          st;
		logic              nbusy;
		logic              ndone;
		logic              pbusy;
		logic              pdone;
		logic [3:0]        ncur;
		logic [3:0]        scan_left;
		logic [2:0]        rep_cnt;
		logic              dly_run;
		logic [7:0]        dly_cnt;
		logic              conv_start;
		logic              conv_abort;
		logic              conv_prio;
		logic [3:0]        conv_chan;
		logic              ub_start;
		logic              nirq;
		logic              pirq;
		logic [1:0]        mirq;
		logic [31:0]       rdata;
	} asq_state_t;

endpackage : asq_pkg

// ==== hw/asq_top.sv ====
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "asq_map.svh"
// How it works
// (RULE1) 8-bit delay count, 0x01-0xFF, resets 0x27
// (RULE2) unit B starts count plus one clocks later
// (RULE3) no unit B trigger before ours issued
// (RULE4) software powers analog, waits 3us first
// (RULE5) mode 00: one channel, done, idle, irq
// (RULE6) mode 01: one scan, done, idle, irq
// (RULE7) mode 10: repeat, done per interval, busy
// (RULE8) mode 11: repeat scans, done each scan
// (RULE9) reading status clears normal done flag
// (RULE10) dual mode allows fixed-channel modes only
// (RULE11) priority preempts, normal resumes same channel
// (RULE12) priority is one single fixed conversion
// (RULE13) priority end: irq, done set, busy cleared
// (RULE14) new priority request abandons running one
// (RULE15) no priority conversion in dual mode
// (RULE16) two monitors with independent enables
// (RULE17) monitor: channel, direction, method, limit
// (RULE18) compare each stored result, count matches
// (RULE19) sequential: irq at limit, mismatch clears
// (RULE20) cumulative: irq and clear at limit
// (RULE21) equal result neither counts nor interrupts
// (RULE22) software leaves monitored result register alone
// (RULE23) dual select: 0 trigger start, 1 interleave
// (RULE24) normal busy set when normal conversion starts
module asq_top (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// conversion core
	output logic             o_conv_start,
	output logic             o_conv_abort,
	output logic             o_conv_prio,
	output logic      [3:0]  o_conv_chan,
	input  wire logic        i_conv_done,
	input  wire logic [11:0] i_conv_result,
	output logic             o_analog_power_on,
	// dual unit
	output logic             o_dual_enable,
	output logic             o_dual_interleave,
	output logic             o_unit_b_start,
	// events
	output logic             o_normal_done_irq,
	output logic             o_priority_done_irq,
	output logic      [1:0]  o_monitor_irq
);

	asq_pkg::asq_state_t s_q;
	asq_pkg::asq_state_t s_d;

	logic wr_ctrl;
	logic rd_stat;
	logic nstart;
	logic pstart;
	logic ndone_ev;
	logic pdone_ev;
	logic scan_en;
	logic rep_en;

	assign wr_ctrl  = i_wr && (i_addr == `ASQ_OFF_CTRL);
	assign rd_stat  = i_rd && (i_addr == `ASQ_OFF_STAT);
	assign nstart   = wr_ctrl && i_wdata[`ASQ_CTRL_NSTART];
	assign pstart   = wr_ctrl && i_wdata[`ASQ_CTRL_PSTART];
	assign ndone_ev = i_conv_done && (s_q.st == asq_pkg::ASQ_NORM);
	assign pdone_ev = i_conv_done && (s_q.st == asq_pkg::ASQ_PRIO);
	// scan is forced off in dual unit operation
	assign scan_en  = s_q.cfg.rs[`ASQ_MODE_SCAN] && !s_q.cfg.dual; // [RULE10]
	assign rep_en   = s_q.cfg.rs[`ASQ_MODE_REP];

	always_comb begin
		logic        gt;
		logic        lt;
		logic        hit;
		logic [4:0]  nxt;
		logic [31:0] mrd;
		gt  = 1'b0;
		lt  = 1'b0;
		hit = 1'b0;
		nxt = 5'h00;
		mrd = 32'h0000_0000;
		s_d = s_q;
		s_d.conv_start = 1'b0;
		s_d.conv_abort = 1'b0;
		s_d.ub_start   = 1'b0;
		s_d.nirq       = 1'b0;
		s_d.pirq       = 1'b0;
		s_d.mirq       = 2'h0;

		// register writes
		if (wr_ctrl) begin
			s_d.cfg.power = i_wdata[`ASQ_CTRL_POWER];
			s_d.cfg.dual  = i_wdata[`ASQ_CTRL_DUAL];
			s_d.cfg.dsel  = i_wdata[`ASQ_CTRL_DSEL]; // [RULE23]
		end
		if (i_wr && (i_addr == `ASQ_OFF_MODE)) begin
			s_d.cfg.rs     = i_wdata[`ASQ_MODE_RS];
			s_d.cfg.nch    = i_wdata[`ASQ_MODE_NCH];
			s_d.cfg.pch    = i_wdata[`ASQ_MODE_PCH];
			s_d.cfg.sfirst = i_wdata[`ASQ_MODE_SFIRST];
			s_d.cfg.sspan  = i_wdata[`ASQ_MODE_SSPAN];
			s_d.cfg.repeat_irq_interval    = i_wdata[`ASQ_MODE_ITM];
		end
		// zero is outside the legal range and is ignored
		if (i_wr && (i_addr == `ASQ_OFF_DELAY)
		    && (i_wdata[`ASQ_DELAY_F] >= `ASQ_DELAY_MIN)) begin
			s_d.cfg.delay = i_wdata[`ASQ_DELAY_F]; // [RULE1]
		end
		for (int i = 0; i < 2; i++) begin
			if (i_wr && (i_addr == ((i == 0) ? `ASQ_OFF_MON0
			                                 : `ASQ_OFF_MON1))) begin
				s_d.mon[i].en     = i_wdata[`ASQ_MON_EN]; // [RULE16]
				s_d.mon[i].chan   = i_wdata[`ASQ_MON_CHAN]; // [RULE17]
				s_d.mon[i].dir    = i_wdata[`ASQ_MON_DIR];
				s_d.mon[i].method = i_wdata[`ASQ_MON_METH];
				s_d.mon[i].limit  = i_wdata[`ASQ_MON_LIM];
				s_d.mon[i].thr    = i_wdata[`ASQ_MON_THR];
				s_d.mcnt[i]       = 4'h0;
			end
		end

		// register reads, answer stands one cycle later
		s_d.rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
			`ASQ_OFF_CTRL: begin
				s_d.rdata[`ASQ_CTRL_POWER] = s_q.cfg.power;
				s_d.rdata[`ASQ_CTRL_DUAL]  = s_q.cfg.dual;
				s_d.rdata[`ASQ_CTRL_DSEL]  = s_q.cfg.dsel;
			end
			`ASQ_OFF_MODE: begin
				s_d.rdata[`ASQ_MODE_RS]     = s_q.cfg.rs;
				s_d.rdata[`ASQ_MODE_NCH]    = s_q.cfg.nch;
				s_d.rdata[`ASQ_MODE_PCH]    = s_q.cfg.pch;
				s_d.rdata[`ASQ_MODE_SFIRST] = s_q.cfg.sfirst;
				s_d.rdata[`ASQ_MODE_SSPAN]  = s_q.cfg.sspan;
				s_d.rdata[`ASQ_MODE_ITM]    = s_q.cfg.repeat_irq_interval;
			end
			`ASQ_OFF_STAT: begin
				s_d.rdata[`ASQ_STAT_NDONE] = s_q.ndone;
				s_d.rdata[`ASQ_STAT_NBUSY] = s_q.nbusy;
				s_d.rdata[`ASQ_STAT_PDONE] = s_q.pdone;
				s_d.rdata[`ASQ_STAT_PBUSY] = s_q.pbusy;
			end
			`ASQ_OFF_DELAY: begin
				s_d.rdata[`ASQ_DELAY_F] = s_q.cfg.delay; // [RULE1]
			end
			`ASQ_OFF_MON0, `ASQ_OFF_MON1: begin
				for (int i = 0; i < 2; i++) begin
					if (i_addr == ((i == 0) ? `ASQ_OFF_MON0
					                        : `ASQ_OFF_MON1)) begin
						mrd[`ASQ_MON_EN]   = s_q.mon[i].en;
						mrd[`ASQ_MON_CHAN] = s_q.mon[i].chan;
						mrd[`ASQ_MON_DIR]  = s_q.mon[i].dir;
						mrd[`ASQ_MON_METH] = s_q.mon[i].method;
						mrd[`ASQ_MON_LIM]  = s_q.mon[i].limit;
						mrd[`ASQ_MON_THR]  = s_q.mon[i].thr;
					end
				end
				s_d.rdata = mrd;
			end
			default: begin
				s_d.rdata = 32'h0000_0000;
			end
			endcase
		end
		// read clears; a done event later in this process wins
		if (rd_stat) begin
			s_d.ndone = 1'b0; // [RULE9]
			s_d.pdone = 1'b0; // [RULE13]
		end

		// priority conversion finished
		if (pdone_ev) begin
			s_d.st    = asq_pkg::ASQ_IDLE;
			s_d.pbusy = 1'b0; // [RULE13]
			s_d.pdone = 1'b1;
			s_d.pirq  = 1'b1;
		end

		// normal conversion finished
		if (ndone_ev) begin
			s_d.st = asq_pkg::ASQ_IDLE;
			if (scan_en) begin
				if (s_q.scan_left == 4'h0) begin
					s_d.ndone = 1'b1; // [RULE6] [RULE8]
					s_d.nirq  = 1'b1;
					if (rep_en) begin
						s_d.ncur      = s_q.cfg.sfirst;
						s_d.scan_left = s_q.cfg.sspan;
					end else begin
						s_d.nbusy = 1'b0;
					end
				end else begin
					s_d.ncur      = s_q.ncur + 4'h1;
					s_d.scan_left = s_q.scan_left - 4'h1;
				end
			end else if (rep_en) begin
				if (s_q.rep_cnt == s_q.cfg.repeat_irq_interval) begin
					s_d.rep_cnt = 3'h0; // [RULE7]
					s_d.ndone   = 1'b1;
					s_d.nirq    = 1'b1;
				end else begin
					s_d.rep_cnt = s_q.rep_cnt + 3'h1;
				end
			end else begin
				s_d.ndone = 1'b1; // [RULE5]
				s_d.nbusy = 1'b0;
				s_d.nirq  = 1'b1;
			end
			// each normal result is checked by every enabled monitor set to its channel
			for (int i = 0; i < 2; i++) begin
				gt  = i_conv_result > s_q.mon[i].thr;
				lt  = i_conv_result < s_q.mon[i].thr;
				hit = s_q.mon[i].dir ? gt : lt; // [RULE18]
				nxt = {1'b0, s_q.mcnt[i]} + 5'h01;
				if (s_q.mon[i].en && (s_q.mon[i].chan == s_q.conv_chan)
				    && (gt || lt)) begin // [RULE21]
					if (!s_q.mon[i].method) begin
						if (hit) begin
							if (nxt >= {1'b0, s_q.mon[i].limit}) begin
								s_d.mirq[i] = 1'b1; // [RULE19]
							end
							if (nxt <= {1'b0, s_q.mon[i].limit}) begin
								s_d.mcnt[i] = nxt[3:0];
							end
						end else begin
							s_d.mcnt[i] = 4'h0; // [RULE19]
						end
					end else if (hit) begin
						if (nxt >= {1'b0, s_q.mon[i].limit}) begin
							s_d.mirq[i] = 1'b1; // [RULE20]
							s_d.mcnt[i] = 4'h0;
						end else begin
							s_d.mcnt[i] = nxt[3:0];
						end
					end
				end
			end
		end

		// normal start or restart discards any running normal pass
		if (nstart) begin
			if (s_q.st == asq_pkg::ASQ_NORM) begin
				s_d.conv_abort = 1'b1;
				s_d.st         = asq_pkg::ASQ_IDLE;
			end
			s_d.nbusy     = 1'b1; // [RULE24]
			s_d.ndone     = 1'b0;
			s_d.rep_cnt   = 3'h0;
			s_d.scan_left = s_d.cfg.sspan;
			s_d.ncur      = (s_d.cfg.rs[`ASQ_MODE_SCAN] && !s_d.cfg.dual)
			                ? s_d.cfg.sfirst : s_d.cfg.nch;
		end

		// priority request; ncur is left so normal resumes there
		if (pstart && !s_d.cfg.dual) begin // [RULE15]
			if (s_d.st != asq_pkg::ASQ_IDLE) begin
				s_d.conv_abort = 1'b1; // [RULE11] [RULE14]
				s_d.st         = asq_pkg::ASQ_IDLE;
			end
			s_d.pbusy = 1'b1;
		end

		// unit B start delay
		if (s_q.dly_run) begin
			if (s_q.dly_cnt == 8'h00) begin
				s_d.ub_start = 1'b1; // [RULE2]
				s_d.dly_run  = 1'b0;
			end else begin
				s_d.dly_cnt = s_q.dly_cnt - 8'h01;
			end
		end

		// issue next conversion, priority first
		if ((s_q.st == asq_pkg::ASQ_IDLE)
		    && (s_d.st == asq_pkg::ASQ_IDLE)) begin
			if (s_d.pbusy) begin
				s_d.st         = asq_pkg::ASQ_PRIO;
				s_d.conv_start = 1'b1;
				s_d.conv_prio  = 1'b1;
				s_d.conv_chan  = s_d.cfg.pch; // [RULE12]
			end else if (s_d.nbusy) begin
				s_d.st         = asq_pkg::ASQ_NORM;
				s_d.conv_start = 1'b1;
				s_d.conv_prio  = 1'b0;
				s_d.conv_chan  = s_d.ncur;
				if (s_d.cfg.dual) begin
					s_d.dly_run = 1'b1; // [RULE2]
					s_d.dly_cnt = s_d.cfg.delay;
				end
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q           <= '0;
			s_q.cfg.delay <= `ASQ_DELAY_RST; // [RULE1]
			s_q.st        <= asq_pkg::ASQ_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata             = s_q.rdata;
	assign o_conv_start        = s_q.conv_start;
	assign o_conv_abort        = s_q.conv_abort;
	assign o_conv_prio         = s_q.conv_prio;
	assign o_conv_chan         = s_q.conv_chan;
	assign o_analog_power_on   = s_q.cfg.power;
	assign o_dual_enable       = s_q.cfg.dual;
	assign o_dual_interleave   = s_q.cfg.dsel;
	assign o_unit_b_start      = s_q.ub_start;
	assign o_normal_done_irq   = s_q.nirq;
	assign o_priority_done_irq = s_q.pirq;
	assign o_monitor_irq       = s_q.mirq;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	delay_load_a: assert property ( // [RULE2]
		(s_q.conv_start && !s_q.conv_prio && s_q.cfg.dual)
		|-> (s_q.dly_run && (s_q.dly_cnt == s_q.cfg.delay)))
		else $error("unit B delay not loaded at start");
	delay_fire_a: assert property ( // [RULE2]
		(s_q.dly_run && (s_q.dly_cnt == 8'h00)) |=> o_unit_b_start)
		else $error("unit B start missing after delay");
	delay_zero_a: assert property ( // [RULE1]
		(i_wr && (i_addr == `ASQ_OFF_DELAY)
		 && (i_wdata[`ASQ_DELAY_F] == 8'h00))
		|=> $stable(s_q.cfg.delay))
		else $error("zero delay count accepted");
	busy_set_a: assert property ( // [RULE24]
		nstart |=> (s_q.nbusy && !s_q.ndone))
		else $error("normal busy not set on start");
	single_end_a: assert property ( // [RULE5]
		(ndone_ev && !scan_en && !rep_en && !nstart && !pstart)
		|=> (!s_q.nbusy && s_q.ndone && o_normal_done_irq))
		else $error("single conversion end wrong");
	repeat_busy_a: assert property ( // [RULE7]
		(ndone_ev && rep_en && !nstart) |=> s_q.nbusy)
		else $error("busy dropped in repeat mode");
	done_clear_a: assert property ( // [RULE9]
		(rd_stat && !ndone_ev) |=> !s_q.ndone)
		else $error("normal done not cleared by read");
	prio_end_a: assert property ( // [RULE13]
		(pdone_ev && !pstart)
		|=> (!s_q.pbusy && s_q.pdone && o_priority_done_irq))
		else $error("priority end flags wrong");
	preempt_a: assert property ( // [RULE11]
		((s_q.st == asq_pkg::ASQ_NORM) && pstart
		 && !i_wdata[`ASQ_CTRL_DUAL] && !i_conv_done) |=> o_conv_abort ##1
		(o_conv_start && o_conv_prio))
		else $error("priority did not preempt");
	no_prio_dual_a: assert property ( // [RULE15]
		(pstart && i_wdata[`ASQ_CTRL_DUAL] && !s_q.pbusy) |=> !s_q.pbusy)
		else $error("priority accepted in dual mode");
	mon_equal_a: assert property ( // [RULE21]
		(ndone_ev && (i_conv_result == s_q.mon[0].thr)
		 && !(i_wr && (i_addr == `ASQ_OFF_MON0)))
		|=> (!o_monitor_irq[0] && $stable(s_q.mcnt[0])))
		else $error("monitor counted an equal result");

	prio_cov_c: cover property (
		(s_q.st == asq_pkg::ASQ_NORM) && pstart);
	scan_cov_c: cover property (ndone_ev && scan_en && s_q.scan_left == 4'h0);
	ub_cov_c: cover property (o_unit_b_start);
	mon_cov_c: cover property (o_monitor_irq != 2'h0);

endmodule : asq_top

// ==== verification/asq_core_model.sv ====
`timescale 1ns/1ps
module asq_core_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// sequencer side
	input  wire logic        i_start,
	input  wire logic        i_abort,
	input  wire logic [11:0] i_value,
	input  wire logic [3:0]  i_lat,
	output logic             o_done,
	output logic      [11:0] o_result
);
	logic        busy_q;
	logic [3:0]  cnt_q;
	logic [11:0] val_q;

	// one done per start that is not aborted; result bus is junk otherwise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_q   <= 1'b0;
			cnt_q    <= 4'h0;
			val_q    <= 12'h000;
			o_done   <= 1'b0;
			o_result <= 12'hA5A;
		end else begin
			o_done   <= 1'b0;
			o_result <= ~o_result;
			if (i_abort) begin
				busy_q <= 1'b0;
			end else if (i_start) begin
				busy_q <= 1'b1;
				cnt_q  <= i_lat;
				val_q  <= i_value;
			end else if (busy_q && cnt_q == 4'h0) begin
				busy_q   <= 1'b0;
				o_done   <= 1'b1;
				o_result <= val_q;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule : asq_core_model

// ==== verification/asq_top_tb.sv ====
`timescale 1ns/1ps
`include "asq_map.svh"
module asq_top_tb;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  addr  = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic [11:0] val   = 12'h000;
	logic [3:0]  lat   = 4'h2;
	logic [31:0] rdata;
	logic        c_start, c_abort, c_prio, c_done, pwr, d_en, d_il, ub;
	logic        n_irq, p_irq;
	logic [3:0]  c_chan;
	logic [11:0] c_res;
	logic [1:0]  m_irq;
	logic [4:0]  chq[$];
	int n_mismatch = 0;
	int total_checks = 0;
	int n_st, n_ab, n_ni, n_pi, n_m0, n_m1, cyc, t_st, t_ub;
	localparam logic [11:0] SEQ [12] = '{12'h800, 12'h900, 12'h900,
		12'h900, 12'h100, 12'h900, 12'h100, 12'h100, 12'h100, 12'h100,
		12'h100, 12'h100};

	always #2 i_clk = ~i_clk;

	asq_top uut (
		.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_conv_start(c_start),
		.o_conv_abort(c_abort), .o_conv_prio(c_prio), .o_conv_chan(c_chan),
		.i_conv_done(c_done), .i_conv_result(c_res),
		.o_analog_power_on(pwr), .o_dual_enable(d_en),
		.o_dual_interleave(d_il), .o_unit_b_start(ub),
		.o_normal_done_irq(n_irq), .o_priority_done_irq(p_irq),
		.o_monitor_irq(m_irq)
	);

	asq_core_model core (
		.i_clk(i_clk), .i_rst(i_rst), .i_start(c_start), .i_abort(c_abort),
		.i_value(val), .i_lat(lat), .o_done(c_done), .o_result(c_res)
	);

	// event log; next result value is queued ahead of each start
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (c_start) begin
			n_st <= n_st + 1;
			t_st <= cyc;
			chq.push_back({c_prio, c_chan});
			val  <= SEQ[(n_st + 1) % 12];
		end
		if (ub) t_ub <= cyc;
		if (c_abort) n_ab <= n_ab + 1;
		if (n_irq) n_ni <= n_ni + 1;
		if (p_irq) n_pi <= n_pi + 1;
		if (m_irq[0]) n_m0 <= n_m0 + 1;
		if (m_irq[1]) n_m1 <= n_m1 + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
		#1;
	endtask : wrr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rdc

	task automatic upto(ref int c, input int n);
		for (int i = 0; i < 500 && c < n; i++) begin
			@(posedge i_clk);
			#1;
		end
		chk(32'(c >= n), 32'h1);
	endtask : upto

	// unit b is never triggered from here, only by the sequencer
	task automatic rst_pwr();
		i_rst <= 1'b1;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		{n_st, n_ab, n_ni, n_pi, n_m0, n_m1, t_st, t_ub} = '0;
		chq.delete();
		wrr(`ASQ_OFF_CTRL, 32'h4);
		repeat (750) @(posedge i_clk);
	endtask : rst_pwr

	task automatic t_regs();
		rst_pwr();
		rdc(`ASQ_OFF_DELAY, 32'h27);
		wrr(`ASQ_OFF_DELAY, 32'hFFFF_FF00);
		rdc(`ASQ_OFF_DELAY, 32'h27);
		wrr(`ASQ_OFF_DELAY, 32'hFFFF_FFFF);
		rdc(`ASQ_OFF_DELAY, 32'hFF);
		rdc(8'h3C, 32'h0);
		rdc(`ASQ_OFF_STAT, 32'h0);
		chk(32'(pwr), 32'h1);
	endtask : t_regs

	task automatic t_single();
		rst_pwr();
		lat <= 4'h9;
		wrr(`ASQ_OFF_MODE, 32'h14);
		wrr(`ASQ_OFF_CTRL, 32'h5);
		rdc(`ASQ_OFF_STAT, 32'h2);
		upto(n_ni, 1);
		chk(n_st, 1);
		chk(chq[0], 5'h05);
		rdc(`ASQ_OFF_STAT, 32'h1);
		rdc(`ASQ_OFF_STAT, 32'h0);
	endtask : t_single

	task automatic t_scan();
		rst_pwr();
		lat <= 4'h2;
		wrr(`ASQ_OFF_MODE, 32'h8801);
		wrr(`ASQ_OFF_CTRL, 32'h5);
		upto(n_ni, 1);
		repeat (20) @(posedge i_clk);
		chk(n_st, 3);
		for (int i = 0; i < 3; i++) chk(chq[i], 5'(i + 2));
		rdc(`ASQ_OFF_STAT, 32'h1);
	endtask : t_scan

	task automatic t_rep();
		rst_pwr();
		lat <= 4'h9;
		wrr(`ASQ_OFF_MODE, 32'h4001E);
		wrr(`ASQ_OFF_CTRL, 32'h5);
		upto(n_ni, 2);
		chk(n_st, 4);
		for (int i = 0; i < 4; i++) chk(chq[i], 5'h07);
		rdc(`ASQ_OFF_STAT, 32'h3);
	endtask : t_rep

	task automatic t_screp();
		rst_pwr();
		lat <= 4'h2;
		wrr(`ASQ_OFF_MODE, 32'h7803);
		wrr(`ASQ_OFF_CTRL, 32'h5);
		upto(n_ni, 2);
		chk(n_st, 4);
		for (int i = 0; i < 4; i++) chk(chq[i], 5'(14 + i % 2));
		rdc(`ASQ_OFF_STAT, 32'h3);
	endtask : t_screp

	task automatic t_prio();
		rst_pwr();
		lat <= 4'h9;
		wrr(`ASQ_OFF_MODE, 32'h24E);
		wrr(`ASQ_OFF_CTRL, 32'h5);
		upto(n_st, 1);
		wrr(`ASQ_OFF_CTRL, 32'h6);
		upto(n_pi, 1);
		chk(n_ab, 1);
		chk(chq[1], 5'h19);
		rdc(`ASQ_OFF_STAT, 32'h6);
		rdc(`ASQ_OFF_STAT, 32'h2);
		upto(n_st, 3);
		chk(chq[2], 5'h03);
		wrr(`ASQ_OFF_MODE, 32'h28E);
		wrr(`ASQ_OFF_CTRL, 32'h6);
		upto(n_st, 4);
		wrr(`ASQ_OFF_CTRL, 32'h6);
		upto(n_pi, 2);
		chk(n_ab, 3);
		chk(chq[4], 5'h1A);
	endtask : t_prio

	task automatic t_dual();
		rst_pwr();
		lat <= 4'h2;
		wrr(`ASQ_OFF_DELAY, 32'h1);
		wrr(`ASQ_OFF_MODE, 32'h2411);
		wrr(`ASQ_OFF_CTRL, 32'hC);
		chk({d_en, d_il}, 32'h2);
		wrr(`ASQ_OFF_CTRL, 32'hD);
		upto(n_ni, 1);
		chk(t_ub - t_st, 2);
		chk(n_st, 1);
		chk(chq[0], 5'h04);
		wrr(`ASQ_OFF_CTRL, 32'hE);
		repeat (20) @(posedge i_clk);
		chk(n_st, 1);
		wrr(`ASQ_OFF_CTRL, 32'h1C);
		chk({d_en, d_il}, 32'h3);
	endtask : t_dual

	// monitored result is never read back by software
	task automatic t_mon();
		rst_pwr();
		lat <= 4'h2;
		val <= SEQ[0];
		wrr(`ASQ_OFF_MON0, 32'h0800_0123);
		wrr(`ASQ_OFF_MON1, 32'h0800_0143);
		wrr(`ASQ_OFF_MODE, 32'h6);
		wrr(`ASQ_OFF_CTRL, 32'h5);
		upto(n_st, 10);
		chk(n_m0, 2);
		chk(n_m1, 2);
	endtask : t_mon

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	initial begin
		#200000;
		n_mismatch++;
		test_done();
	end

	initial begin
		t_regs();
		t_single();
		t_scan();
		t_rep();
		t_screp();
		t_prio();
		t_dual();
		t_mon();
		test_done();
	end
endmodule : asq_top_tb
